// *** bench/ict_contact_model.sv ***
// model of the control contact and the interrupter switch
`timescale 1ns/100ps
`default_nettype none
module ict_contact_model (
    // clock and request
    input wire logic core_clk,
    input wire logic want_close,
    // switch side
    input wire logic intr_closed,
    output logic ctl_contact,
    output logic [15:0] toggles
);
    // one driver per output; start values given at declaration
    logic contact_q = 1'b0;
    logic last_q = 1'b1;
    logic [15:0] count_q = 16'h0000;
    assign ctl_contact = contact_q;
    assign toggles = count_q;
    // closed contact asks to close, open contact asks to open
    always @(posedge core_clk) contact_q <= want_close;
    // count switch operations
    always @(posedge core_clk) begin
        last_q <= intr_closed;
        if (last_q !== intr_closed) count_q <= count_q + 16'h0001;
    end
endmodule
`default_nettype wire

// *** bench/ict_timer_chk.sv ***
// assertion checker for the interrupter cycle timer
`timescale 1ns/100ps
`default_nettype none
module ict_timer_chk #(
    parameter int MS_CYCLES = 4
) (
    // clock, reset and bus
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic ctl_contact,
    input wire logic intr_closed,
    input wire logic run_led
);
    // ***
    // shadow state
    // ***
    logic mode_q, wr, span;
    logic [26:0] start_q, stop_q, now_q;
    logic [15:0] on_q, off_q;
    logic [16:0] run_q;
    logic [1:0] ph_q;
    logic tw_q;
    assign wr = psel && penable && pwrite;
    assign span = start_q <= now_q && now_q < stop_q;
    // track register writes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_q <= 1'b0;
            start_q <= '0;
            stop_q <= '0;
            now_q <= '0;
            on_q <= 16'h03E8;
            off_q <= 16'h03E8;
        end else if (wr) begin
            case (paddr)
                8'h00: mode_q <= pwdata[0];
                8'h08: start_q <= pwdata[26:0];
                8'h0C: stop_q <= pwdata[26:0];
                8'h10: now_q <= pwdata[26:0];
                8'h04: begin
                    on_q <= pwdata[31] ? 16'(pwdata[25:16]) :
                        pwdata[5:0] > 6'h3C ? 16'h00C8 : pwdata[5:0] * 16'h03E8;
                    off_q <= pwdata[31] ? 16'h03E8 - pwdata[25:16] :
                        pwdata[5:0] > 6'h3C ? 16'h0320 : pwdata[13:8] * 16'h03E8;
                end
                default: ;
            endcase
        end
    end
    // level length and phases seen inside the span
    // a phase loaded at the timing write edge still has the old length
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            run_q <= '0;
            ph_q <= '0;
            tw_q <= 1'b0;
        end else begin
            tw_q <= wr && paddr == 8'h04;
            run_q <= $changed(intr_closed) ? 17'h0_0001 : run_q + 17'h0_0001;
            if (!(mode_q && span) || (wr && paddr == 8'h04) || tw_q)
                ph_q <= '0;
            else if ($changed(intr_closed) && ph_q != 2'h3)
                ph_q <= ph_q + 2'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_led_off: assert property (!intr_closed |-> !run_led)
        else $error("indicator lit while open");
    chk_led_on: assert property (intr_closed |-> run_led)
        else $error("indicator dark while closed");
    chk_ext_close: assert property ((!mode_q && ctl_contact)[*7] |-> intr_closed)
        else $error("switch not closed after contact closed");
    chk_ext_open: assert property ((!mode_q && !ctl_contact)[*7] |-> !intr_closed)
        else $error("switch not open after contact opened");
    chk_int_ignore: assert property ((mode_q && !span && !ctl_contact)[*3] |-> intr_closed)
        else $error("contact obeyed in internal mode");
    chk_span_end: assert property (mode_q && $fell(span) |-> ##[1:3] intr_closed)
        else $error("switch not closed after span end");
    chk_on_len: assert property ($fell(intr_closed) && mode_q && span && ph_q >= 2'h2 |->
        run_q + MS_CYCLES + 3 >= on_q * MS_CYCLES && run_q <= on_q * MS_CYCLES + MS_CYCLES + 3)
        else $error("on phase length wrong");
    chk_off_len: assert property ($rose(intr_closed) && mode_q && span && ph_q != 2'h0 |->
        run_q + MS_CYCLES + 3 >= off_q * MS_CYCLES && run_q <= off_q * MS_CYCLES + MS_CYCLES + 3)
        else $error("off phase length wrong");
    cov_cycle: cover property ($fell(intr_closed) && mode_q && span && ph_q >= 2'h2);
    cov_ext: cover property ($rose(intr_closed) && !mode_q);
    cov_end: cover property (mode_q && $fell(span));
endmodule
bind ict_timer ict_timer_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// *** bench/ict_timer_tb.sv ***
// self-checking bench for the interrupter cycle timer
`timescale 1ns/100ps
`default_nettype none
module ict_timer_tb;
    logic core_clk, reset, psel, penable, pwrite, want_close, se;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, ctl_contact, intr_closed, run_led;
    logic [15:0] toggles;
    int err_count, check_count;
    ict_timer #(.MS_CYCLES(4)) dut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctl_contact(ctl_contact),
        .intr_closed(intr_closed), .run_led(run_led));
    ict_contact_model model (.core_clk(core_clk), .want_close(want_close),
        .intr_closed(intr_closed), .ctl_contact(ctl_contact), .toggles(toggles));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            check(pready, 1);
            final_report();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_out(input logic e);
        int n;
        n = 0;
        while (intr_closed !== e && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        check(intr_closed, e);
        check(run_led, e);
        if (intr_closed !== e) final_report();
    endtask
    task automatic wait_tog(input int lim);
        logic [15:0] b;
        int n;
        b = toggles;
        n = 0;
        while (toggles - b < 16'h0004 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        check(toggles - b >= 16'h0004, 1);
        if (toggles - b < 16'h0004) final_report();
    endtask
    task automatic t_reset();
        apb(0, 8'h00, 0);
        check(rd, 0);
        apb(0, 8'h04, 0);
        check(rd, 32'h00C8_0101);
        apb(0, 8'h18, 0);
        check(rd, 32'h0000_0000);
        check(se, 1);
        $display("reset test done");
    endtask
    task automatic t_ext();
        repeat (2) begin
            want_close <= 1'b1;
            wait_out(1);
            want_close <= 1'b0;
            wait_out(0);
        end
        apb(1, 8'h0C, 32'h07FF_FFFF);
        apb(0, 8'h0C, 0);
        check(rd, 32'h07FF_FFFF);
        apb(1, 8'h10, 32'h0000_0001);
        repeat (2000) @(posedge core_clk);
        check(intr_closed, 0);
        $display("external test done");
    endtask
    task automatic t_regs();
        apb(1, 8'h08, 32'h0523_4567);
        apb(0, 8'h08, 0);
        check(rd, 32'h0523_4567);
        check(se, 0);
        apb(1, 8'h04, 32'h0000_003D);
        apb(0, 8'h04, 0);
        check(rd & 32'h83FF_0000, 32'h80C8_0000);
        apb(1, 8'h04, 32'h8384_0000);
        apb(0, 8'h04, 0);
        check(rd & 32'h83FF_0000, 32'h8320_0000);
        apb(1, 8'h04, 32'h0000_3C00);
        apb(0, 8'h04, 0);
        check(rd & 32'h8000_3F3F, 32'h0000_3C01);
        $display("register test done");
    endtask
    task automatic t_int();
        apb(1, 8'h08, 0);
        apb(1, 8'h04, 32'h812C_0000);
        apb(1, 8'h00, 32'h0000_0001);
        wait_tog(10000);
        apb(0, 8'h14, 0);
        check(rd[1], 1);
        apb(1, 8'h04, 32'h0000_0201);
        wait_tog(30000);
        apb(1, 8'h10, 32'h07FF_FFFF);
        wait_out(1);
        apb(1, 8'h00, 0);
        wait_out(0);
        $display("internal test done");
    endtask
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        want_close = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_ext();
        t_regs();
        t_int();
        final_report();
    end
endmodule
`default_nettype wire

// *** design/ict_timer.sv ***
// interrupter cycle timer with apb register access
//
// Operation
// - external mode: interrupter output follows the control input level.
// - run indicator is off while the interrupter is open.
// - run indicator is on while the interrupter is closed.
// - timing, start and stop settings act only in internal mode.
// - seconds range: on and off each 1 to 60 s, independent.
// - setting past 60 s enters millisecond range at 200 on, 800 off; code: on-time only, off past 60 s clamps to 60.
// - millisecond range: fixed 1000 ms cycle, on-time 200 to 800 ms.
// - millisecond range: off-time derived as 1000 ms minus on-time.
// - start and stop held as hour, minute, day, month, year fields.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ict_cfg.svh"

module ict_timer import ict_pkg::*; #(
    parameter int MS_CYCLES = `ICT_CYC_PER_MS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control contact pin, high = closed contact
    input wire logic ctl_contact,
    // interrupter switch, high = closed
    output logic intr_closed,
    // front panel run indicator
    output logic run_led
);

    // ***************************************************
    // elaboration check
    // ***************************************************
    if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end

    // ***************************************************
    // helper functions
    // ***************************************************
    // keep a seconds value within 1..60
    function automatic logic [5:0] clamp_sec(input logic [5:0] v);
        if (v < `ICT_SEC_MIN) begin
            return `ICT_SEC_MIN;
        end
        if (v > `ICT_SEC_MAX) begin
            return `ICT_SEC_MAX;
        end
        return v;
    endfunction

    // keep a millisecond on-time within 200..800
    function automatic logic [9:0] clamp_ms(input logic [9:0] v);
        if (v < `ICT_MS_MIN) begin
            return `ICT_MS_MIN;
        end
        if (v > `ICT_MS_MAX) begin
            return `ICT_MS_MAX;
        end
        return v;
    endfunction

    // phase length in ms for on (1) or off (0)
    function automatic logic [15:0] phase_ms(input ict_time_type t,
                                             input logic on);
        logic [15:0] secs;
        secs = {10'h000, on ? t.on_sec : t.off_sec};
        if (t.ms_range) begin
            if (on) begin
                return {6'h00, t.ms_on};
            end
            return {6'h00, `ICT_MS_CYCLE - t.ms_on};
        end
        return 16'(secs * `ICT_MS_PER_SEC);
    endfunction

    // ***************************************************
    // registers and signals
    // ***************************************************
    logic mode_int_q;
    ict_time_type time_q;
    ict_dt_type start_q;
    ict_dt_type stop_q;
    ict_dt_type now_q;
    logic [31:0] rdata_q;
    logic [2:0] sync_q;
    logic ctl_level_q;
    logic [15:0] tick_cnt_q;
    logic tick_q;
    logic [15:0] phase_cnt_q;
    ict_state_type state_q;
    logic closed_q;
    logic in_window;
    logic addr_ok;
    logic wr_en;
    logic [5:0] wr_on;
    logic [5:0] wr_off;

    // ***************************************************
    // apb decode
    // ***************************************************
    // zero wait states; unmapped addresses answer with an error
    always_comb begin
        case (paddr)
            `ICT_CTRL_OFF,
            `ICT_TIME_OFF,
            `ICT_START_OFF,
            `ICT_STOP_OFF,
            `ICT_NOW_OFF,
            `ICT_STAT_OFF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign wr_on = pwdata[`ICT_ON_SEC_LSB +: 6];
    assign wr_off = pwdata[`ICT_OFF_SEC_LSB +: 6];
    assign prdata = rdata_q;

    // read data captured in the setup cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= 32'h0000_0000;
            case (paddr)
                `ICT_CTRL_OFF: rdata_q[`ICT_CTRL_MODE] <= mode_int_q;
                `ICT_TIME_OFF: begin
                    rdata_q[`ICT_ON_SEC_LSB +: 6] <= time_q.on_sec;
                    rdata_q[`ICT_OFF_SEC_LSB +: 6] <= time_q.off_sec;
                    rdata_q[`ICT_MS_ON_LSB +: 10] <= time_q.ms_on;
                    rdata_q[`ICT_MS_RANGE] <= time_q.ms_range;
                end
                `ICT_START_OFF: rdata_q[26:0] <= start_q;
                `ICT_STOP_OFF: rdata_q[26:0] <= stop_q;
                `ICT_NOW_OFF: rdata_q[26:0] <= now_q;
                `ICT_STAT_OFF: begin
                    rdata_q[`ICT_ST_CLOSED] <= closed_q;
                    rdata_q[`ICT_ST_WINDOW] <= in_window;
                    rdata_q[`ICT_ST_CTL] <= ctl_level_q;
                    rdata_q[`ICT_ST_OFF_PHASE] <= (state_q == ICT_OFF);
                end
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ***************************************************
    // configuration registers
    // ***************************************************
    // mode select, 1 = internal cycling
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_int_q <= 1'b0;
        end else if (wr_en && paddr == `ICT_CTRL_OFF) begin
            mode_int_q <= pwdata[`ICT_CTRL_MODE];
        end
    end

    // on/off timing; on above 60 s rolls into the ms range
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            time_q.ms_range <= 1'b0;
            time_q.on_sec <= `ICT_SEC_RST;
            time_q.off_sec <= `ICT_SEC_RST;
            time_q.ms_on <= `ICT_MS_ON_RST;
        end else if (wr_en && paddr == `ICT_TIME_OFF) begin
            if (pwdata[`ICT_MS_RANGE]) begin
                time_q.ms_range <= 1'b1;
                time_q.ms_on <= clamp_ms(pwdata[`ICT_MS_ON_LSB +: 10]);
            end else if (wr_on > `ICT_SEC_MAX) begin
                time_q.ms_range <= 1'b1;
                time_q.ms_on <= `ICT_MS_MIN;
            end else begin
                time_q.ms_range <= 1'b0;
                time_q.on_sec <= clamp_sec(wr_on);
                time_q.off_sec <= clamp_sec(wr_off);
            end
        end
    end

    // start, stop and current date-time stamps
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            start_q <= `ICT_DT_RST;
            stop_q <= `ICT_DT_RST;
            now_q <= `ICT_DT_RST;
        end else if (wr_en) begin
            case (paddr)
                `ICT_START_OFF: start_q <= pwdata[26:0];
                `ICT_STOP_OFF: stop_q <= pwdata[26:0];
                `ICT_NOW_OFF: now_q <= pwdata[26:0];
                default: ;
            endcase
        end
    end

    // active span; a stop not after start gives no span
    assign in_window = (now_q >= start_q) && (now_q < stop_q);

    // ***************************************************
    // control contact synchroniser
    // ***************************************************
    // three stages, level accepted when stages two and three agree
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync_q <= 3'b000;
            ctl_level_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], ctl_contact};
            if (sync_q[1] == sync_q[2]) begin
                ctl_level_q <= sync_q[2];
            end
        end
    end

    // ***************************************************
    // millisecond tick
    // ***************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 16'(MS_CYCLES - 1)) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ***************************************************
    // internal on/off cycle
    // ***************************************************
    // runs only in internal mode inside the span
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= ICT_IDLE;
            phase_cnt_q <= 16'h0000;
        end else if (!mode_int_q || !in_window) begin
            state_q <= ICT_IDLE;
            phase_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                ICT_IDLE: begin
                    state_q <= ICT_ON;
                    phase_cnt_q <= phase_ms(time_q, 1'b1);
                end
                ICT_ON: begin
                    if (tick_q) begin
                        if (phase_cnt_q <= 16'h0001) begin
                            state_q <= ICT_OFF;
                            phase_cnt_q <= phase_ms(time_q, 1'b0);
                        end else begin
                            phase_cnt_q <= phase_cnt_q - 16'h0001;
                        end
                    end
                end
                ICT_OFF: begin
                    if (tick_q) begin
                        if (phase_cnt_q <= 16'h0001) begin
                            state_q <= ICT_ON;
                            phase_cnt_q <= phase_ms(time_q, 1'b1);
                        end else begin
                            phase_cnt_q <= phase_cnt_q - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_q <= ICT_IDLE;
                    phase_cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // ***************************************************
    // interrupter and indicator
    // ***************************************************
    // external mode mirrors contact; internal opens only in off phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            closed_q <= 1'b1;
        end else if (!mode_int_q) begin
            closed_q <= ctl_level_q;
        end else begin
            closed_q <= (state_q != ICT_OFF);
        end
    end

    assign intr_closed = closed_q;
    assign run_led = closed_q;

endmodule
`default_nettype wire

// *** include/ict_cfg.svh ***
// constants for the interrupter cycle timer: offsets, fields, resets, timing
`ifndef ICT_CFG_SVH
`define ICT_CFG_SVH
// register byte offsets
`define ICT_CTRL_OFF 8'h00
`define ICT_TIME_OFF 8'h04
`define ICT_START_OFF 8'h08
`define ICT_STOP_OFF 8'h0C
`define ICT_NOW_OFF 8'h10
`define ICT_STAT_OFF 8'h14
// control fields
`define ICT_CTRL_MODE 0
// timing fields
`define ICT_ON_SEC_LSB 0
`define ICT_OFF_SEC_LSB 8
`define ICT_MS_ON_LSB 16
`define ICT_MS_RANGE 31
// status fields
`define ICT_ST_CLOSED 0
`define ICT_ST_WINDOW 1
`define ICT_ST_CTL 2
`define ICT_ST_OFF_PHASE 3
// reset values
`define ICT_SEC_RST 6'h01
`define ICT_MS_ON_RST 10'h0C8
`define ICT_DT_RST 27'h000_0000
// limits and timing
`define ICT_SEC_MIN 6'h01
`define ICT_SEC_MAX 6'h3C
`define ICT_MS_MIN 10'h0C8
`define ICT_MS_MAX 10'h320
`define ICT_MS_CYCLE 10'h3E8
`define ICT_MS_PER_SEC 16'h03E8
`define ICT_CLK_NS 25
`define ICT_MS_NS 1000000
`define ICT_CYC_PER_MS (`ICT_MS_NS / `ICT_CLK_NS)
`endif

// *** include/ict_pkg.sv ***
// types for the interrupter cycle timer
package ict_pkg;
    // calendar stamp; field order makes plain compare chronological
    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
    } ict_dt_type;
    // timing settings
    typedef struct packed {
        logic ms_range;
        logic [5:0] on_sec;
        logic [5:0] off_sec;
        logic [9:0] ms_on;
    } ict_time_type;
    // cycle state, gray along idle -> on -> off
    typedef enum logic [1:0] {
        ICT_IDLE = 2'b00,
        ICT_ON = 2'b01,
        ICT_OFF = 2'b11
    } ict_state_type;
endpackage
